// file: logic/phy_vendor_regs_pkg.sv
// Constants and types for the vendor management register pair
package phy_vendor_regs_pkg;
   // Management register addresses
   localparam logic [4:0] VCFG_ADDR = 5'h10;
   localparam logic [4:0] VSTAT_ADDR = 5'h11;
   // Values after reset, and the config write mask
   localparam logic [15:0] VCFG_RESET = 16'h0414;
   localparam logic [15:0] VCFG_WMASK = 16'hFCF7;
   localparam logic [3:0] AN_FLAGS_RESET = 4'hF;
   localparam logic RSV9_RESET = 1'b1;
   localparam logic [4:0] PHYAD_RESET = 5'h01;
   // Field positions in the config register
   localparam int FLINK_BIT = 7;
   localparam int RPD_BIT = 4;
   localparam int FSMRST_BIT = 3;
   localparam int PRE_BIT = 2;
   localparam int SLEEP_BIT = 1;
   localparam int LOOP_BIT = 0;
   // Frame field codes
   localparam logic [1:0] START_CODE = 2'b01;
   localparam logic [1:0] OP_READ = 2'b10;
   localparam logic [1:0] OP_WRITE = 2'b01;
   // Cycle and bit counts
   localparam logic [5:0] PREAMBLE_ONES = 6'd32;
   localparam logic [4:0] HDR_LAST = 5'd13;
   localparam logic [4:0] RX_LAST = 5'd17;
   localparam logic [4:0] RD_BITS = 5'd16;
   localparam logic [4:0] FSM_RST_CYCLES = 5'd16;
   // Serial management frame states
   typedef enum logic [4:0] {
      MS_PRE = 5'b00001,
      MS_HDR = 5'b00010,
      MS_RDTA = 5'b00100,
      MS_RD = 5'b01000,
      MS_RX = 5'b10000
   } mgmt_state_type;
endpackage : phy_vendor_regs_pkg

// file: logic/phy_vendor_config_status_regs.sv
// Vendor config and status registers behind the serial management port
`timescale 1ns/1ns
module phy_vendor_config_status_regs (
   input wire logic core_clk_in,
   input wire logic sys_rst_in,
   input wire logic mdc_in,
   input wire logic mdio_in,
   output logic mdio_out,
   output logic mdio_oe_out,
   input wire logic link_raw_in,
   input wire logic an_done_in,
   input wire logic [3:0] an_result_in,
   input wire logic [3:0] an_monitor_in,
   output logic link_good_100_out,
   output logic auto_power_reduce_en_out,
   output logic fsm_reset_out,
   output logic mgmt_preamble_suppress_out,
   output logic sleep_out,
   output logic loop_out_en_out,
   output logic isolate_out
);
   ////////////////////////////////////////////////////////////////////////
   // Declarations
   logic [1:0] mdc_sync; // Clock pin synchroniser
   logic [1:0] mdio_sync; // Data pin synchroniser
   logic [1:0] link_sync; // Line link synchroniser
   logic mdc_prev; // Last synced clock level
   phy_vendor_regs_pkg::mgmt_state_type state; // Frame state
   logic [5:0] pre_cnt; // Preamble ones seen
   logic [4:0] bit_cnt; // Bit index in phase
   logic [15:0] shreg; // Shift register both ways
   logic [4:0] reg_sel; // Addressed register
   logic [4:0] frame_phy; // Address taken from frame
   logic wr_hit; // Matched write in flight
   logic [15:0] cfg; // Config register
   logic [3:0] an_flags; // Negotiated mode flags
   logic rsv9; // Reserved writable bit
   logic [4:0] phy_addr; // Own PHY address
   logic [3:0] an_mon; // Negotiation monitor copy
   logic [4:0] rst_cnt; // Reset cycles left
   logic fsm_busy; // State machine reset running
   ////////////////////////////////////////////////////////////////////////
   // Decoding
   wire mdc_rise = mdc_sync[1] & ~mdc_prev;
   wire rx_bit = mdio_sync[1];
   wire [15:0] rx_word = {shreg[14:0], rx_bit};
   wire [13:0] hdr = rx_word[13:0];
   wire hdr_done = mdc_rise && state == phy_vendor_regs_pkg::MS_HDR && bit_cnt == phy_vendor_regs_pkg::HDR_LAST;
   wire hdr_hit = hdr[13:12] == phy_vendor_regs_pkg::START_CODE && hdr[9:5] == phy_addr;
   wire wr_fire = mdc_rise && state == phy_vendor_regs_pkg::MS_RX && wr_hit
                  && bit_cnt == phy_vendor_regs_pkg::RX_LAST;
   wire wr_cfg = wr_fire && reg_sel == phy_vendor_regs_pkg::VCFG_ADDR;
   wire wr_stat = wr_fire && reg_sel == phy_vendor_regs_pkg::VSTAT_ADDR;
   wire wake = wr_cfg && cfg[phy_vendor_regs_pkg::SLEEP_BIT] && !rx_word[phy_vendor_regs_pkg::SLEEP_BIT];
   wire rst_start = (wr_cfg && rx_word[phy_vendor_regs_pkg::FSMRST_BIT]) || wake;
   wire pre_ok = pre_cnt == phy_vendor_regs_pkg::PREAMBLE_ONES || cfg[phy_vendor_regs_pkg::PRE_BIT];
   wire [15:0] cfg_rd = {cfg[15:4], fsm_busy, cfg[2:0]};
   wire [15:0] stat_rd = {an_flags, 2'b00, rsv9, phy_addr, an_mon};
   wire [15:0] rdata = reg_sel == phy_vendor_regs_pkg::VCFG_ADDR ? cfg_rd
                     : reg_sel == phy_vendor_regs_pkg::VSTAT_ADDR ? stat_rd : 16'h0000;
   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers
   always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         mdc_sync <= 2'b00;
         mdio_sync <= 2'b11;
         link_sync <= 2'b00;
         mdc_prev <= 1'b0;
      end else begin
         mdc_sync <= {mdc_sync[0], mdc_in};
         mdio_sync <= {mdio_sync[0], mdio_in};
         link_sync <= {link_sync[0], link_raw_in};
         mdc_prev <= mdc_sync[1];
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // Management frame engine, advances on clock pin rising edges
   always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         state <= phy_vendor_regs_pkg::MS_PRE;
         pre_cnt <= 6'd0;
         bit_cnt <= 5'd0;
         shreg <= 16'h0000;
         reg_sel <= 5'd0;
         frame_phy <= 5'd0;
         wr_hit <= 1'b0;
         mdio_out <= 1'b0;
         mdio_oe_out <= 1'b0;
      end else if (mdc_rise) begin
         case (state)
            phy_vendor_regs_pkg::MS_PRE: begin
               // Count ones; a zero after enough of them, or any zero with preamble suppressed, opens the frame
               if (rx_bit) begin
                  if (pre_cnt != phy_vendor_regs_pkg::PREAMBLE_ONES) pre_cnt <= pre_cnt + 6'd1;
               end else if (pre_ok) begin
                  state <= phy_vendor_regs_pkg::MS_HDR;
                  shreg <= rx_word;
                  bit_cnt <= 5'd1;
               end else begin
                  pre_cnt <= 6'd0;
               end
            end
            phy_vendor_regs_pkg::MS_HDR: begin
               // Start, opcode, address MSB first, register
               shreg <= rx_word;
               bit_cnt <= bit_cnt + 5'd1;
               if (hdr_done) begin
                  reg_sel <= hdr[4:0];
                  frame_phy <= hdr[9:5];
                  bit_cnt <= 5'd0;
                  wr_hit <= hdr_hit && hdr[11:10] == phy_vendor_regs_pkg::OP_WRITE;
                  if (hdr_hit && hdr[11:10] == phy_vendor_regs_pkg::OP_READ) state <= phy_vendor_regs_pkg::MS_RDTA;
                  else state <= phy_vendor_regs_pkg::MS_RX;
               end
            end
            phy_vendor_regs_pkg::MS_RDTA: begin
               // Second turnaround bit driven low
               mdio_oe_out <= 1'b1;
               mdio_out <= 1'b0;
               shreg <= rdata;
               state <= phy_vendor_regs_pkg::MS_RD;
            end
            phy_vendor_regs_pkg::MS_RD: begin
               // Sixteen data bits MSB first, then release
               if (bit_cnt == phy_vendor_regs_pkg::RD_BITS) begin
                  mdio_oe_out <= 1'b0;
                  state <= phy_vendor_regs_pkg::MS_PRE;
                  pre_cnt <= 6'd0;
                  bit_cnt <= 5'd0;
               end else begin
                  mdio_out <= shreg[15];
                  shreg <= {shreg[14:0], 1'b0};
                  bit_cnt <= bit_cnt + 5'd1;
               end
            end
            phy_vendor_regs_pkg::MS_RX: begin
               // Turnaround and data, written only when matched
               shreg <= rx_word;
               bit_cnt <= bit_cnt + 5'd1;
               if (bit_cnt == phy_vendor_regs_pkg::RX_LAST) begin
                  state <= phy_vendor_regs_pkg::MS_PRE;
                  pre_cnt <= 6'd0;
                  bit_cnt <= 5'd0;
                  wr_hit <= 1'b0;
               end
            end
            default: state <= phy_vendor_regs_pkg::MS_PRE;
         endcase
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // Register storage; sleep leaves config untouched so wake restores it
   always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         cfg <= phy_vendor_regs_pkg::VCFG_RESET;
         rsv9 <= phy_vendor_regs_pkg::RSV9_RESET;
         phy_addr <= phy_vendor_regs_pkg::PHYAD_RESET;
      end else if (wr_cfg) begin
         cfg <= rx_word & phy_vendor_regs_pkg::VCFG_WMASK;
      end else if (wr_stat) begin
         rsv9 <= rx_word[9];
         phy_addr <= rx_word[8:4];
      end
   end
   // Negotiation result capture
   always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         an_flags <= phy_vendor_regs_pkg::AN_FLAGS_RESET;
         an_mon <= 4'h0;
      end else begin
         if (an_done_in) an_flags <= an_result_in;
         an_mon <= an_monitor_in;
      end
   end
   // Self-clearing state machine reset, a new start wins over finishing
   always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         rst_cnt <= 5'd0;
         fsm_busy <= 1'b0;
      end else if (rst_start) begin
         rst_cnt <= phy_vendor_regs_pkg::FSM_RST_CYCLES - 5'd1;
         fsm_busy <= 1'b1;
      end else if (fsm_busy) begin
         if (rst_cnt == 5'd0) fsm_busy <= 1'b0;
         else rst_cnt <= rst_cnt - 5'd1;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // Registered control outputs
   always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         link_good_100_out <= 1'b0;
         auto_power_reduce_en_out <= 1'b1;
         fsm_reset_out <= 1'b0;
         mgmt_preamble_suppress_out <= 1'b1;
         sleep_out <= 1'b0;
         loop_out_en_out <= 1'b0;
         isolate_out <= 1'b0;
      end else begin
         link_good_100_out <= cfg[phy_vendor_regs_pkg::FLINK_BIT] | link_sync[1];
         auto_power_reduce_en_out <= cfg[phy_vendor_regs_pkg::RPD_BIT];
         fsm_reset_out <= rst_start | (fsm_busy && rst_cnt != 5'd0);
         mgmt_preamble_suppress_out <= cfg[phy_vendor_regs_pkg::PRE_BIT];
         sleep_out <= cfg[phy_vendor_regs_pkg::SLEEP_BIT];
         loop_out_en_out <= cfg[phy_vendor_regs_pkg::LOOP_BIT];
         isolate_out <= phy_addr == 5'd0;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // Assertions
   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (sys_rst_in);
   AST_LINK_FORCE: assert property (cfg[7] |=> link_good_100_out) else $error("forced link not shown");
   AST_LINK_NORMAL: assert property (!cfg[7] |=> link_good_100_out == $past(link_sync[1]))
      else $error("link not tracking line");
   AST_RPD: assert property (1'b1 |=> auto_power_reduce_en_out == $past(cfg[4])) else $error("rpd mismatch");
   AST_RST_START: assert property (rst_start |=> fsm_reset_out && cfg_rd[3]) else $error("reset not begun");
   AST_RST_END: assert property (fsm_busy && rst_cnt == 5'd0 && !rst_start |=> !cfg_rd[3] && !fsm_reset_out)
      else $error("reset bit not cleared");
   AST_PRE: assert property (1'b1 |=> mgmt_preamble_suppress_out == $past(cfg[2])) else $error("pre mismatch");
   AST_SLEEP: assert property (wr_cfg && rx_word[1] |-> ##2 sleep_out) else $error("sleep not entered");
   AST_WAKE: assert property ($fell(cfg[1]) |-> fsm_busy && fsm_reset_out) else $error("wake wrong");
   // Config only moves on a management write, so sleep cannot disturb it
   AST_CFG_HOLD: assert property (!wr_cfg |=> $stable(cfg)) else $error("config changed without write");
   AST_LOOP: assert property (1'b1 |=> loop_out_en_out == $past(cfg[0])) else $error("loop mismatch");
   AST_AN: assert property (an_done_in |=> an_flags == $past(an_result_in)) else $error("an flags lost");
   AST_ADDR: assert property (state == phy_vendor_regs_pkg::MS_RDTA |-> frame_phy == phy_addr)
      else $error("read for other address");
   AST_ISO: assert property (phy_addr == 5'd0 |=> isolate_out) else $error("isolate not set");
   AST_LOOP_RST: assert property (@(posedge core_clk_in) $fell(sys_rst_in) |-> !cfg[0])
      else $error("loop out not off after reset");
   COV_READ: cover property (state == phy_vendor_regs_pkg::MS_RD && bit_cnt == phy_vendor_regs_pkg::RD_BITS);
   COV_WRITE: cover property (wr_cfg);
   COV_RESET: cover property ($fell(fsm_busy));
   COV_WAKE: cover property (wake);
endmodule : phy_vendor_config_status_regs

// file: bench/mgmt_master_model.sv
// Station management controller model that runs serial management frames
`timescale 1ns/1ns
module mgmt_master_model (
   input wire logic core_clk_in,
   input wire logic mdio_in,
   output logic mdc_out,
   output logic mdio_out,
   output logic mdio_oe_out,
   output logic rd_valid_out,
   output logic [15:0] rd_data_out
);
   // Idle: clock low, pin released
   initial begin
      mdc_out = 1'b0;
      mdio_out = 1'b1;
      mdio_oe_out = 1'b0;
      rd_valid_out = 1'b0;
      rd_data_out = 16'h0000;
   end
   ////////////////////////////////////////////////////////////////////////////
   // One bit period: data set in low phase, sampled just before the rise
   task automatic clk_bit(input logic drv, input logic b, output logic s);
      mdio_oe_out <= drv;
      mdio_out <= drv ? b : ~mdio_out;
      repeat (8) @(posedge core_clk_in);
      s = mdio_in;
      mdc_out <= 1'b1;
      repeat (8) @(posedge core_clk_in);
      mdc_out <= 1'b0;
   endtask : clk_bit
   // Whole frame; a read hands its word on as a one-clock strobe
   task automatic frame(input int pre, input logic [1:0] op, input logic [4:0] phy, input logic [4:0] ra,
                        input logic [15:0] wd);
      logic [13:0] hdr;
      logic [15:0] rd;
      logic s;
      hdr = {phy_vendor_regs_pkg::START_CODE, op, phy, ra};
      @(posedge core_clk_in);
      repeat (pre) clk_bit(1'b1, 1'b1, s);
      // Address and register sent most significant bit first
      for (int i = 13; i >= 0; i--) clk_bit(1'b1, hdr[i], s);
      if (op == phy_vendor_regs_pkg::OP_WRITE) begin
         clk_bit(1'b1, 1'b1, s);
         clk_bit(1'b1, 1'b0, s);
         for (int i = 15; i >= 0; i--) clk_bit(1'b1, wd[i], s);
      end else begin
         // Released through turnaround and data: two turnaround bits, then 16 data bits
         for (int i = 0; i < 18; i++) begin
            clk_bit(1'b0, 1'b1, s);
            // Sample before rise i sees the bit driven after the previous rise
            if (i >= 2) rd[17 - i] = s;
         end
         rd_data_out <= rd;
         rd_valid_out <= 1'b1;
         @(posedge core_clk_in);
         rd_valid_out <= 1'b0;
      end
      mdio_oe_out <= 1'b0;
   endtask : frame
endmodule : mgmt_master_model

// file: bench/tb_phy_vendor_config_status_regs.sv
// Self-checking bench for the vendor config and status registers
`timescale 1ns/1ns
module tb_phy_vendor_config_status_regs;
   logic core_clk_in, sys_rst_in, mdc, mdio_m, mdio_m_oe, mdio_d, mdio_d_oe, mdio_wire, rd_valid;
   logic link_raw_in, an_done_in, link_good, apr_en, fsm_rst, pre_sup, sleep, loop_en, isolate;
   logic [3:0] an_result_in, an_monitor_in;
   logic [15:0] rd_data;
   logic [15:0] exp_q[$]; // Expected read words, oldest first
   int n_errors, cmp_count, cyc, run_len, last_len;
   // Pin has a pull-up when nobody drives it
   assign mdio_wire = mdio_d_oe ? mdio_d : (mdio_m_oe ? mdio_m : 1'b1);
   phy_vendor_config_status_regs phy_vendor_config_status_regs_i (.core_clk_in(core_clk_in),
      .sys_rst_in(sys_rst_in), .mdc_in(mdc), .mdio_in(mdio_wire), .mdio_out(mdio_d), .mdio_oe_out(mdio_d_oe),
      .link_raw_in(link_raw_in), .an_done_in(an_done_in), .an_result_in(an_result_in),
      .an_monitor_in(an_monitor_in), .link_good_100_out(link_good), .auto_power_reduce_en_out(apr_en),
      .fsm_reset_out(fsm_rst), .mgmt_preamble_suppress_out(pre_sup), .sleep_out(sleep),
      .loop_out_en_out(loop_en), .isolate_out(isolate));
   mgmt_master_model mgmt_master_model_i (.core_clk_in(core_clk_in), .mdio_in(mdio_wire), .mdc_out(mdc),
      .mdio_out(mdio_m), .mdio_oe_out(mdio_m_oe), .rd_valid_out(rd_valid), .rd_data_out(rd_data));
   always #5 core_clk_in = ~core_clk_in;
   ////////////////////////////////////////////////////////////////////////////
   task automatic stop_test();
      $display("Comparisons %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : stop_test
   task automatic cmp(input string what, input logic [15:0] e, input logic [15:0] g);
      cmp_count++;
      if (g !== e) begin
         n_errors++;
         $display("Error %s expected %h seen %h", what, e, g);
      end
   endtask : cmp
   task automatic rd(input logic [4:0] a, input logic [4:0] r, input logic [15:0] e, input int pre = 32);
      exp_q.push_back(e);
      mgmt_master_model_i.frame(pre, phy_vendor_regs_pkg::OP_READ, a, r, 16'h0000);
   endtask : rd
   task automatic wr(input logic [4:0] a, input logic [4:0] r, input logic [15:0] d);
      last_len = 0;
      mgmt_master_model_i.frame(32, phy_vendor_regs_pkg::OP_WRITE, a, r, d);
      repeat (30) @(posedge core_clk_in);
   endtask : wr
   // Output flags as {link, power reduce, preamble, sleep, loop, isolate}
   task automatic outs(input logic [5:0] e);
      // Looked at mid-cycle, away from the edge that launches the outputs
      @(negedge core_clk_in);
      cmp("outputs", {10'h000, e}, {10'h000, link_good, apr_en, pre_sup, sleep, loop_en, isolate});
   endtask : outs
   ////////////////////////////////////////////////////////////////////////////
   // Read watcher, state machine reset length, and hang limit
   always @(posedge core_clk_in) begin
      cyc++;
      if (rd_valid === 1'b1) cmp("read_data", exp_q.pop_front(), rd_data);
      if (fsm_rst === 1'b1) begin
         run_len++;
      end else if (run_len != 0) begin
         last_len = run_len;
         run_len = 0;
      end
      if (cyc == 30000) begin
         n_errors++;
         stop_test();
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      logic [15:0] w;
      logic [3:0] an;
      core_clk_in = 1'b0;
      sys_rst_in = 1'b1;
      link_raw_in = 1'b0;
      an_done_in = 1'b0;
      an_result_in = 4'h0;
      w = $urandom(32'h9eec_fcf3);
      an_monitor_in = 4'($urandom);
      repeat (2) @(posedge core_clk_in);
      sys_rst_in <= 1'b0;
      outs(6'b011000);
      rd(5'h01, phy_vendor_regs_pkg::VCFG_ADDR, phy_vendor_regs_pkg::VCFG_RESET, 0);
      rd(5'h01, phy_vendor_regs_pkg::VSTAT_ADDR, {4'hF, 3'b001, 5'h01, an_monitor_in});
      link_raw_in <= 1'b1;
      repeat (6) @(posedge core_clk_in);
      outs(6'b111000);
      link_raw_in <= 1'b0;
      // Random config: reset start, sleep, wake, plain write
      for (int k = 0; k < 4; k++) begin
         w = 16'($urandom);
         w[7] = k[0];
         w[3] = (k == 0);
         w[1] = (k == 1);
         wr(5'h01, phy_vendor_regs_pkg::VCFG_ADDR, w);
         cmp("fsm_reset_len", (k == 0 || k == 2) ? 16'h0010 : 16'h0000, 16'(last_len));
         outs({w[7], w[4], w[2], w[1], w[0], 1'b0});
         rd(5'h01, phy_vendor_regs_pkg::VCFG_ADDR, w & phy_vendor_regs_pkg::VCFG_WMASK);
      end
      // Negotiation result read only after completion
      an = 4'($urandom);
      an_result_in <= an;
      an_done_in <= 1'b1;
      @(posedge core_clk_in);
      an_done_in <= 1'b0;
      rd(5'h01, phy_vendor_regs_pkg::VSTAT_ADDR, {an, 3'b001, 5'h01, an_monitor_in});
      rd(5'h01, 5'h05, 16'h0000);
      // New address 00101, reserved bit written as zero
      wr(5'h01, phy_vendor_regs_pkg::VSTAT_ADDR, 16'h0050);
      rd(5'h01, phy_vendor_regs_pkg::VCFG_ADDR, 16'hFFFF);
      rd(5'h14, phy_vendor_regs_pkg::VCFG_ADDR, 16'hFFFF);
      rd(5'h05, phy_vendor_regs_pkg::VSTAT_ADDR, {an, 3'b000, 5'h05, an_monitor_in});
      wr(5'h05, phy_vendor_regs_pkg::VSTAT_ADDR, 16'h0000);
      cmp("isolate", 16'h0001, {15'h0000, isolate});
      wr(5'h00, phy_vendor_regs_pkg::VSTAT_ADDR, 16'h0010);
      cmp("isolate", 16'h0000, {15'h0000, isolate});
      repeat (20) @(posedge core_clk_in);
      cmp("pending_reads", 16'h0000, 16'(exp_q.size()));
      stop_test();
   end
endmodule : tb_phy_vendor_config_status_regs
